// [i2c_buffers_and_addressing_tb_top.sv]
// Self-checking bench for the I2C buffer and addressing block
`default_nettype none
module i2c_buffers_and_addressing_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] rd;
   logic [15:0] v;
   logic [7:0]  b, q;
   logic        ack;
   wire logic [31:0] hrdata;
   wire logic   hro, irq, sda_oe, scl, pull, sda;
   int          error_cnt = 0;
   int          comparisons = 0;
   int          cyc = 0;
   // Open-drain data wire with a pull-up
   assign sda = ~(sda_oe | pull);
   i2cba_top dut (.MCLK(mclk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hro), .HRDATA(hrdata),
      .HREADYOUT(hro), .HRESP(), .IRQ(irq), .SCL_I(scl), .SDA_I(sda), .SDA_O(),
      .SDA_OE(sda_oe));
   i2cba_bus_master m (.scl(scl), .pull(pull), .sda(sda));
   // Clock and hang guard
   always #2.5 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         error_cnt++;
         end_of_test();
      end
   end
   function automatic logic [31:0] own_exp(logic [15:0] x);
      return {16'h0, x[15], 5'h0, x[9:0]};
   endfunction
   task automatic end_of_test();
      if (error_cnt == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   // Single AHB-Lite transfer; each phase held until ready is seen
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge mclk); while (hro !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge mclk); while (hro !== 1'b1);
      rd = hrdata;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string n);
      bus(1'b0, a, 32'h0);
      chk(n, e, rd);
   endtask
   // Main sequence
   initial begin
      void'($urandom(93));
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      rdchk(i2cba_pkg::OFS_OWN, 32'h0, "own");
      rdchk(i2cba_pkg::OFS_STAT, 32'h20, "status");
      rdchk(8'h1c, 32'h0, "unmapped");
      // Reserved bits dropped, enables kept
      for (int i = 0; i < 4; i++) begin
         v = 16'($urandom);
         bus(1'b1, i2cba_pkg::OFS_OWN, {16'h0, v});
         rdchk(i2cba_pkg::OFS_OWN, own_exp(v), "own");
         bus(1'b1, i2cba_pkg::OFS_TGT, {16'h0, v});
         rdchk(i2cba_pkg::OFS_TGT, {22'h0, v[9:0]}, "target");
         bus(1'b1, i2cba_pkg::OFS_IE, {24'h0, v[7:0]});
         rdchk(i2cba_pkg::OFS_IE, {24'h0, v[7:0]}, "irq_enable");
      end
      bus(1'b1, i2cba_pkg::OFS_IE, 32'h0);
      // Slave receive with junk in the ignored own-address bits
      for (int i = 0; i < 3; i++) begin
         v = (16'($urandom) & 16'h03ff) | 16'h0040;
         b = 8'($urandom);
         bus(1'b1, i2cba_pkg::OFS_OWN, {16'h0, v});
         m.start();
         m.xfer({v[6:0], 1'b0}, 1'b1, q, ack);
         chk("addr_ack", 0, ack);
         m.xfer(b, 1'b1, q, ack);
         m.stop();
         rdchk(i2cba_pkg::OFS_STAT, 32'h36, "status");
         rdchk(i2cba_pkg::OFS_RX, {24'h0, b}, "rx");
         bus(1'b0, i2cba_pkg::OFS_STAT, 32'h0);
         chk("rx_flag", 0, rd[4]);
      end
      // Wrong address and general call, disabled then enabled
      for (int i = 0; i < 3; i++) begin
         if (i == 2) bus(1'b1, i2cba_pkg::OFS_OWN, {16'h0, v | 16'h8000});
         m.start();
         m.xfer((i == 0) ? {v[6:0] ^ 7'h01, 1'b0} : 8'h00, 1'b1, q, ack);
         m.stop();
         chk("addr_ack", (i == 2) ? 0 : 1, ack);
      end
      // Interrupt raised, masked and cleared
      bus(1'b1, i2cba_pkg::OFS_IE, 32'h04);
      rdchk(i2cba_pkg::OFS_IE, 32'h04, "irq_enable");
      chk("irq", 1, irq);
      bus(1'b1, i2cba_pkg::OFS_IE, 32'h09);
      rdchk(i2cba_pkg::OFS_IE, 32'h09, "irq_enable");
      chk("irq", 0, irq);
      bus(1'b1, i2cba_pkg::OFS_IE, 32'h04);
      bus(1'b1, i2cba_pkg::OFS_STAT, 32'h04);
      rdchk(i2cba_pkg::OFS_IE, 32'h04, "irq_enable");
      chk("irq", 0, irq);
      // Transmit byte kept, then sent on a slave read
      b = 8'($urandom);
      bus(1'b1, i2cba_pkg::OFS_TX, {24'h0, b});
      bus(1'b0, i2cba_pkg::OFS_STAT, 32'h0);
      chk("tx_flag", 0, rd[5]);
      m.start();
      m.xfer({v[6:0], 1'b1}, 1'b1, q, ack);
      chk("addr_ack", 0, ack);
      m.xfer(8'hff, 1'b1, q, ack);
      m.stop();
      chk("tx_byte", b, q);
      bus(1'b0, i2cba_pkg::OFS_STAT, 32'h0);
      chk("tx_flag", 1, rd[5]);
      // Ten-bit own address: header byte, then the low address byte, then data
      bus(1'b1, i2cba_pkg::OFS_CTRL, 32'h2);
      b = 8'($urandom);
      m.start();
      m.xfer({i2cba_pkg::HDR10, v[9:8], 1'b0}, 1'b1, q, ack);
      chk("addr10_hdr_ack", 0, ack);
      m.xfer(v[7:0], 1'b1, q, ack);
      chk("addr10_low_ack", 0, ack);
      m.xfer(b, 1'b1, q, ack);
      m.stop();
      rdchk(i2cba_pkg::OFS_RX, {24'h0, b}, "rx10");
      // Master mode: target byte goes out first, then the held byte
      v = 16'($urandom);
      bus(1'b1, i2cba_pkg::OFS_TGT, {16'h0, v});
      bus(1'b1, i2cba_pkg::OFS_TX, {24'h0, b});
      bus(1'b1, i2cba_pkg::OFS_CTRL, 32'h1);
      m.start();
      m.xfer(8'hff, 1'b0, q, ack);
      chk("tgt_byte", {v[6:0], 1'b0}, q);
      m.xfer(8'hff, 1'b1, q, ack);
      chk("tx_byte", b, q);
      m.stop();
      end_of_test();
   end
endmodule // i2c_buffers_and_addressing_tb_top
`default_nettype wire

// [i2cba_bus_master.sv]
// Behavioural I2C bus master facing the block's link pins
`default_nettype none
module i2cba_bus_master (
   output logic     scl,   // Link clock, stands high outside frames
   output logic     pull,  // High while pulling data low
   input  wire logic sda   // Resolved data wire
);
   timeunit 1ns;
   timeprecision 100ps;
   // Both lines released at start
   initial begin
      scl = 1'b1;
      pull = 1'b0;
   end
   // One 125 ns bit; data moves well after the clock fall to keep hold time
   task automatic slot(input logic b, output logic s);
      #16 pull = ~b;
      #15 scl = 1'b1;
      #31 s = sda;
      #31 scl = 1'b0;
      #32;
   endtask
   // Data falls while the clock is high
   task automatic start();
      pull = 1'b0;
      #16 scl = 1'b1;
      #62 pull = 1'b1;
      #62 scl = 1'b0;
   endtask
   // Data rises while the clock is high
   task automatic stop();
      #16 pull = 1'b1;
      #15 scl = 1'b1;
      #62 pull = 1'b0;
      #62;
   endtask
   // Eight bits MSB first, then the acknowledge slot
   task automatic xfer(input logic [7:0] d, input logic ao, output logic [7:0] q,
                       output logic ack);
      for (int i = 7; i >= 0; i--) slot(d[i], q[i]);
      slot(ao, ack);
   endtask
endmodule // i2cba_bus_master
`default_nettype wire

// [i2cba_match.sv]
// Address comparator for own address and general call
`default_nettype none
module i2cba_match (
   input  wire logic [7:0] rx_byte,    // Byte just shifted in
   input  wire logic [9:0] own_addr,   // Own address field
   input  wire logic       gc_en,      // General call response enable
   input  wire logic       addr10,     // Own address is ten bits
   input  wire logic       second,     // Byte is second of a ten-bit address
   output logic            hit,        // Byte selects this device
   output logic            gc          // Byte is an accepted general call
);
   // Comparison per addressing mode
   always_comb begin
      gc  = gc_en && !second && (rx_byte == i2cba_pkg::GCALL);
      hit = gc;
      if (second)
         hit = (rx_byte == own_addr[7:0]);
      else if (addr10)
         hit = hit || ((rx_byte[7:3] == i2cba_pkg::HDR10) &&
                       (rx_byte[2:1] == own_addr[9:8]));
      else
         hit = hit || (rx_byte[7:1] == own_addr[6:0]);
   end
endmodule // i2cba_match
`default_nettype wire

// [i2cba_pkg.sv]
// Shared constants and types for the I2C buffer and addressing block
`default_nettype none
package i2cba_pkg;
   // Register byte offsets on the AHB-Lite slave
   localparam logic [7:0] OFS_RX   = 8'h00;
   localparam logic [7:0] OFS_TX   = 8'h04;
   localparam logic [7:0] OFS_OWN  = 8'h08;
   localparam logic [7:0] OFS_TGT  = 8'h0c;
   localparam logic [7:0] OFS_IE   = 8'h10;
   localparam logic [7:0] OFS_STAT = 8'h14;
   localparam logic [7:0] OFS_CTRL = 8'h18;

   // Field positions
   localparam int GCEN_BIT   = 15;
   localparam int EV_AL      = 0;
   localparam int EV_STT     = 1;
   localparam int EV_STP     = 2;
   localparam int EV_NACK    = 3;
   localparam int EV_RX      = 4;
   localparam int EV_TX      = 5;
   localparam int NEV        = 6;
   localparam int CTRL_MST   = 0;
   localparam int CTRL_OWN10 = 1;
   localparam int CTRL_TGT10 = 2;
   localparam int CTRL_MREAD = 3;
   localparam int CTRL_W     = 4;

   // Reset values
   localparam logic [7:0]        RST_RX   = 8'h00;
   localparam logic [7:0]        RST_TX   = 8'h00;
   localparam logic [15:0]       RST_OWN  = 16'h0000;
   localparam logic [9:0]        RST_TGT  = 10'h000;
   localparam logic [7:0]        RST_IE   = 8'h00;
   localparam logic [NEV-1:0]    RST_STAT = 6'h20;
   localparam logic [CTRL_W-1:0] RST_CTRL = 4'h0;
   localparam logic [1:0]        PINS_IDLE = 2'h3;

   // Link constants
   localparam logic [4:0] HDR10     = 5'h1e;
   localparam logic [7:0] GCALL     = 8'h00;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [3:0] ACK_BIT   = 4'h9;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_ADDR  = 3'b001,
      ST_ADDR2 = 3'b010,
      ST_RX    = 3'b011,
      ST_TX    = 3'b100,
      ST_SKIP  = 3'b101
   } i2cba_state_t;

   typedef struct packed {
      logic       write;
      logic [7:0] addr;
   } i2cba_req_t;

   typedef struct packed {
      logic scl;
      logic sda;
   } i2cba_pins_t;
endpackage
`default_nettype wire

// [i2cba_sync2.sv]
// Two-stage synchroniser for the I2C clock and data pins
`default_nettype none
module i2cba_sync2 (
   input  wire logic                   clk,  // Sampling clock
   input  wire logic                   rst,  // Synchronous reset, active high
   input  wire i2cba_pkg::i2cba_pins_t din,  // Raw pin levels
   output var  i2cba_pkg::i2cba_pins_t dout  // Levels after two stages
);
   i2cba_pkg::i2cba_pins_t meta;

   // First stage feeds only the second; idle-high reset avoids a false START
   always_ff @(posedge clk) begin
      if (rst) begin
         meta <= i2cba_pkg::PINS_IDLE;
         dout <= i2cba_pkg::PINS_IDLE;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule // i2cba_sync2
`default_nettype wire

// [i2cba_top.sv]
// I2C buffer, address and interrupt-enable block behind an AHB-Lite slave
//
// Decided for this implementation: the AHB-Lite interface to the registers and the register offsets.
`default_nettype none
module i2cba_top (
   input  wire logic        MCLK,       // Module clock, 200 MHz
   input  wire logic        RST,        // Synchronous reset, active high
   input  wire logic        HSEL,       // Slave select
   input  wire logic [31:0] HADDR,      // Byte address
   input  wire logic [1:0]  HTRANS,     // Transfer type
   input  wire logic        HWRITE,     // Write when high
   input  wire logic [2:0]  HSIZE,      // Word transfers only
   input  wire logic [31:0] HWDATA,     // Write data
   input  wire logic        HREADY,     // Bus ready
   output logic [31:0]      HRDATA,     // Read data
   output logic             HREADYOUT,  // Slave ready
   output logic             HRESP,      // Always OKAY
   output logic             IRQ,        // Level interrupt
   input  wire logic        SCL_I,      // I2C clock level
   input  wire logic        SDA_I,      // I2C data level
   output logic             SDA_O,      // Data drive value, always low
   output logic             SDA_OE      // High while pulling data low
);
   // Bus data phase
   i2cba_pkg::i2cba_req_t dp_req, next_dp_req;
   logic                  dp_valid, next_dp_valid;
   logic                  next_ready;
   logic [31:0]           next_rdata;
   logic                  take, wr_strobe, rd_strobe;

   // Registers
   logic [7:0]                      rx_hold, next_rx_hold;
   logic [7:0]                      tx_hold, next_tx_hold;
   logic [15:0]                     own_reg, next_own_reg;
   logic [9:0]                      tgt_reg, next_tgt_reg;
   logic [7:0]                      ie_reg, next_ie_reg;
   logic [i2cba_pkg::NEV-1:0]       stat, next_stat, set_vec;
   logic [i2cba_pkg::CTRL_W-1:0]    ctrl, next_ctrl;
   logic                            next_irq;

   // Link
   i2cba_pkg::i2cba_state_t state, next_state;
   i2cba_pkg::i2cba_pins_t  pins_s, pins_d;
   logic [3:0] bitcnt, next_bitcnt;
   logic [7:0] shin, next_shin, shout, next_shout;
   logic       drive, next_drive, mst_hdr, next_mst_hdr, hdr2, next_hdr2;
   logic       scl_rise, scl_fall, start_seen, stop_seen;
   logic       ev_start, ev_stop, ev_nack, ev_al, rx_load, tx_take;
   logic       hit, gc, master;

   // Register read multiplexer, used for the registered read answer
   function automatic logic [31:0] read_mux(input logic [7:0] a);
      case (a)
         i2cba_pkg::OFS_RX:   read_mux = {24'h000000, rx_hold};
         i2cba_pkg::OFS_TX:   read_mux = {24'h000000, tx_hold};
         i2cba_pkg::OFS_OWN:  read_mux = {16'h0000, own_reg};
         i2cba_pkg::OFS_TGT:  read_mux = {22'h0, tgt_reg};
         i2cba_pkg::OFS_IE:   read_mux = {24'h000000, ie_reg};
         i2cba_pkg::OFS_STAT: read_mux = {26'h0, stat};
         i2cba_pkg::OFS_CTRL: read_mux = {28'h0000000, ctrl};
         default:             read_mux = 32'h00000000;
      endcase
   endfunction

   i2cba_sync2 u_sync (
      .clk  (MCLK),
      .rst  (RST),
      .din  ({SCL_I, SDA_I}),
      .dout (pins_s)
   );

   i2cba_match u_match (
      .rx_byte   (shin),
      .own_addr  (own_reg[9:0]),
      .gc_en     (own_reg[i2cba_pkg::GCEN_BIT]),
      .addr10    (ctrl[i2cba_pkg::CTRL_OWN10]),
      .second    (state == i2cba_pkg::ST_ADDR2),
      .hit       (hit),
      .gc        (gc)
   );

   // Strobes: writes finish with no wait, reads take one wait state
   assign take      = HSEL && HTRANS[1] && HREADY;
   assign wr_strobe = dp_valid && dp_req.write && HREADY;
   assign rd_strobe = dp_valid && !dp_req.write && !HREADYOUT;
   assign master    = ctrl[i2cba_pkg::CTRL_MST];

   // Bus phase tracking and the registered read answer
   always_comb begin
      next_dp_valid = dp_valid;
      next_dp_req   = dp_req;
      next_ready    = 1'b1;
      next_rdata    = HRDATA;
      if (rd_strobe)
         next_rdata = read_mux(dp_req.addr);
      if (HREADY) begin
         next_dp_valid = take;
         if (take) begin
            next_dp_req = '{write: HWRITE, addr: HADDR[7:0]};
            next_ready  = HWRITE;
         end
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         dp_valid  <= 1'b0;
         dp_req    <= '0;
         HREADYOUT <= 1'b1;
         HRDATA    <= 32'h00000000;
         HRESP     <= 1'b0;
      end else begin
         dp_valid  <= next_dp_valid;
         dp_req    <= next_dp_req;
         HREADYOUT <= next_ready;
         HRDATA    <= next_rdata;
         HRESP     <= 1'b0;
      end
   end

   // Register file; a hardware set beats a same-cycle software clear
   always_comb begin
      next_rx_hold = rx_hold;
      next_tx_hold = tx_hold;
      next_own_reg = own_reg;
      next_tgt_reg = tgt_reg;
      next_ie_reg  = ie_reg;
      next_ctrl    = ctrl;
      next_stat    = stat;
      set_vec      = '0;
      set_vec[i2cba_pkg::EV_AL]   = ev_al;
      set_vec[i2cba_pkg::EV_STT]  = ev_start;
      set_vec[i2cba_pkg::EV_STP]  = ev_stop;
      set_vec[i2cba_pkg::EV_NACK] = ev_nack;
      set_vec[i2cba_pkg::EV_RX]   = rx_load;
      set_vec[i2cba_pkg::EV_TX]   = tx_take;
      if (wr_strobe) begin
         case (dp_req.addr)
            i2cba_pkg::OFS_TX: begin
               next_tx_hold = HWDATA[7:0];
               next_stat[i2cba_pkg::EV_TX] = 1'b0;
            end
            i2cba_pkg::OFS_OWN: begin
               next_own_reg = {HWDATA[15], 5'h00, HWDATA[9:0]};
            end
            i2cba_pkg::OFS_TGT:  next_tgt_reg = HWDATA[9:0];
            i2cba_pkg::OFS_IE:   next_ie_reg = HWDATA[7:0];
            i2cba_pkg::OFS_STAT: next_stat = stat & ~HWDATA[i2cba_pkg::NEV-1:0];
            i2cba_pkg::OFS_CTRL: next_ctrl = HWDATA[i2cba_pkg::CTRL_W-1:0];
            default: ;
         endcase
      end
      if (rd_strobe && (dp_req.addr == i2cba_pkg::OFS_RX))
         next_stat[i2cba_pkg::EV_RX] = 1'b0;
      if (rx_load)
         next_rx_hold = shin;
      next_stat = next_stat | set_vec;
      // New enables count at once, so the line never lags a mask write
      next_irq  = |(next_stat & next_ie_reg[i2cba_pkg::NEV-1:0]);
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         rx_hold <= i2cba_pkg::RST_RX;
         tx_hold <= i2cba_pkg::RST_TX;
         own_reg <= i2cba_pkg::RST_OWN;
         tgt_reg <= i2cba_pkg::RST_TGT;
         ie_reg  <= i2cba_pkg::RST_IE;
         stat    <= i2cba_pkg::RST_STAT;
         ctrl    <= i2cba_pkg::RST_CTRL;
         IRQ     <= 1'b0;
      end else begin
         rx_hold <= next_rx_hold;
         tx_hold <= next_tx_hold;
         own_reg <= next_own_reg;
         tgt_reg <= next_tgt_reg;
         ie_reg  <= next_ie_reg;
         stat    <= next_stat;
         ctrl    <= next_ctrl;
         IRQ     <= next_irq;
      end
   end

   // Pin edges from the synchronised levels only
   assign scl_rise   = pins_s.scl && !pins_d.scl;
   assign scl_fall   = !pins_s.scl && pins_d.scl;
   assign start_seen = pins_s.scl && pins_d.scl && pins_d.sda && !pins_s.sda;
   assign stop_seen  = pins_s.scl && pins_d.scl && !pins_d.sda && pins_s.sda;

   // Link engine: bits counted on rising clock, data changed on falling clock
   always_comb begin
      next_state   = state;
      next_bitcnt  = bitcnt;
      next_shin    = shin;
      next_shout   = shout;
      next_drive   = drive;
      next_mst_hdr = mst_hdr;
      next_hdr2    = hdr2;
      ev_start = 1'b0;
      ev_stop  = 1'b0;
      ev_nack  = 1'b0;
      ev_al    = 1'b0;
      rx_load  = 1'b0;
      tx_take  = 1'b0;
      if (start_seen) begin
         ev_start    = 1'b1;
         next_bitcnt = 4'h0;
         next_drive  = 1'b0;
         if (master) begin
            // Target address only reaches the wire as master
            next_state   = i2cba_pkg::ST_TX;
            next_mst_hdr = 1'b1;
            next_hdr2    = ctrl[i2cba_pkg::CTRL_TGT10];
            if (ctrl[i2cba_pkg::CTRL_TGT10])
               next_shout = {i2cba_pkg::HDR10, tgt_reg[9:8], 1'b0};
            else
               next_shout = {tgt_reg[6:0], ctrl[i2cba_pkg::CTRL_MREAD]};
         end else begin
            next_state = i2cba_pkg::ST_ADDR;
         end
      end else if (stop_seen) begin
         ev_stop      = 1'b1;
         next_state   = i2cba_pkg::ST_IDLE;
         next_drive   = 1'b0;
         next_mst_hdr = 1'b0;
      end else if (state != i2cba_pkg::ST_IDLE && state != i2cba_pkg::ST_SKIP) begin
         if (scl_rise) begin
            next_bitcnt = bitcnt + 4'h1;
            if (bitcnt < i2cba_pkg::BYTE_BITS)
               next_shin = {shin[6:0], pins_s.sda};
            if (state == i2cba_pkg::ST_TX && master && bitcnt < i2cba_pkg::BYTE_BITS &&
                shout[7] && !pins_s.sda) begin
               ev_al      = 1'b1;
               next_state = i2cba_pkg::ST_SKIP;
               next_drive = 1'b0;
            end
            if (state == i2cba_pkg::ST_TX && bitcnt == i2cba_pkg::BYTE_BITS && pins_s.sda) begin
               ev_nack    = 1'b1;
               next_state = i2cba_pkg::ST_SKIP;
            end
         end else if (scl_fall) begin
            if (bitcnt == i2cba_pkg::BYTE_BITS) begin
               case (state)
                  i2cba_pkg::ST_ADDR: begin
                     if (!hit)
                        next_state = i2cba_pkg::ST_SKIP;
                     else begin
                        next_drive = 1'b1;
                        if (ctrl[i2cba_pkg::CTRL_OWN10] && !gc)
                           next_state = i2cba_pkg::ST_ADDR2;
                        else if (shin[0] && !gc)
                           next_state = i2cba_pkg::ST_TX;
                        else
                           next_state = i2cba_pkg::ST_RX;
                     end
                  end
                  i2cba_pkg::ST_ADDR2: begin
                     next_drive = hit;
                     next_state = hit ? i2cba_pkg::ST_RX : i2cba_pkg::ST_SKIP;
                  end
                  i2cba_pkg::ST_RX: begin
                     rx_load    = 1'b1;
                     next_drive = 1'b1;
                  end
                  i2cba_pkg::ST_TX: next_drive = 1'b0;
                  default: ;
               endcase
            end else if (bitcnt == i2cba_pkg::ACK_BIT) begin
               next_bitcnt = 4'h0;
               next_drive  = 1'b0;
               if (state == i2cba_pkg::ST_TX) begin
                  if (mst_hdr && hdr2) begin
                     next_hdr2  = 1'b0;
                     next_shout = tgt_reg[7:0];
                     next_drive = !tgt_reg[7];
                  end else if (mst_hdr && ctrl[i2cba_pkg::CTRL_MREAD] &&
                               !ctrl[i2cba_pkg::CTRL_TGT10]) begin
                     next_mst_hdr = 1'b0;
                     next_state   = i2cba_pkg::ST_RX;
                  end else begin
                     // Holding byte moves only here, so software may refill it
                     next_mst_hdr = 1'b0;
                     tx_take      = 1'b1;
                     next_shout   = tx_hold;
                     next_drive   = !tx_hold[7];
                  end
               end
            end else if (state == i2cba_pkg::ST_TX) begin
               if (bitcnt == 4'h0)
                  next_drive = !shout[7];
               else begin
                  next_shout = {shout[6:0], 1'b0};
                  next_drive = !shout[6];
               end
            end
         end
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         state   <= i2cba_pkg::ST_IDLE;
         pins_d  <= i2cba_pkg::PINS_IDLE;
         bitcnt  <= 4'h0;
         shin    <= 8'h00;
         shout   <= 8'h00;
         drive   <= 1'b0;
         mst_hdr <= 1'b0;
         hdr2    <= 1'b0;
         SDA_OE  <= 1'b0;
         SDA_O   <= 1'b0;
      end else begin
         state   <= next_state;
         pins_d  <= pins_s;
         bitcnt  <= next_bitcnt;
         shin    <= next_shin;
         shout   <= next_shout;
         drive   <= next_drive;
         mst_hdr <= next_mst_hdr;
         hdr2    <= next_hdr2;
         SDA_OE  <= next_drive;
         SDA_O   <= 1'b0;
      end
   end

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);

   sequence s_read_req;
      HSEL && HTRANS[1] && HREADY && !HWRITE;
   endsequence
   sequence s_one_wait;
      !HREADYOUT ##1 HREADYOUT;
   endsequence

   AST_READ_WAIT: assert property (s_read_req |=> s_one_wait)
      else $error("read did not finish after one wait state");
   AST_RX_LOAD: assert property (rx_load |=> rx_hold == $past(shin))
      else $error("receive holding not loaded with shifted byte");
   AST_RX_CLEAR: assert property (rd_strobe && dp_req.addr == i2cba_pkg::OFS_RX && !rx_load
                                  |=> !stat[i2cba_pkg::EV_RX])
      else $error("receive flag not cleared by read");
   AST_TX_HOLD: assert property (tx_take |=> shout == $past(tx_hold) &&
                                 stat[i2cba_pkg::EV_TX])
      else $error("transmit byte not moved to shifter");
   AST_TX_CLEAR: assert property (wr_strobe && dp_req.addr == i2cba_pkg::OFS_TX && !tx_take
                                  |=> !stat[i2cba_pkg::EV_TX])
      else $error("transmit flag not cleared by write");
   AST_GCALL_OFF: assert property (scl_fall && !start_seen && !stop_seen &&
                                   state == i2cba_pkg::ST_ADDR && bitcnt == i2cba_pkg::BYTE_BITS &&
                                   shin == i2cba_pkg::GCALL && !own_reg[i2cba_pkg::GCEN_BIT] &&
                                   own_reg[6:0] != 7'h00
                                   |=> state == i2cba_pkg::ST_SKIP && !SDA_OE)
      else $error("general call answered while disabled");
   AST_OWN7: assert property (scl_fall && !start_seen && !stop_seen &&
                              state == i2cba_pkg::ST_ADDR && bitcnt == i2cba_pkg::BYTE_BITS &&
                              !ctrl[i2cba_pkg::CTRL_OWN10] && shin[7:1] == own_reg[6:0]
                              |=> SDA_OE && state != i2cba_pkg::ST_SKIP)
      else $error("own seven-bit address not acknowledged");
   AST_OWN10: assert property (scl_fall && !start_seen && !stop_seen &&
                               state == i2cba_pkg::ST_ADDR2 && bitcnt == i2cba_pkg::BYTE_BITS &&
                               shin == own_reg[7:0]
                               |=> state == i2cba_pkg::ST_RX && SDA_OE)
      else $error("own ten-bit address not acknowledged");
   AST_TGT7: assert property (start_seen && master && !ctrl[i2cba_pkg::CTRL_TGT10]
                              |=> shout == {tgt_reg[6:0], ctrl[i2cba_pkg::CTRL_MREAD]})
      else $error("target address byte wrong");
   AST_SLAVE_NO_TGT: assert property (start_seen && !master
                                      |=> state == i2cba_pkg::ST_ADDR)
      else $error("slave start did not enter address phase");
   AST_RESV_ZERO: assert property (rd_strobe && dp_req.addr == i2cba_pkg::OFS_OWN
                                   |=> HRDATA[14:10] == 5'h00 && HRDATA[31:16] == 16'h0000)
      else $error("reserved own-address bits not zero");
   AST_IRQ: assert property (IRQ == |(stat & ie_reg[i2cba_pkg::NEV-1:0]))
      else $error("interrupt line disagrees with flags and enables");
   AST_RX_FLAG: assert property (rx_load |=> stat[i2cba_pkg::EV_RX] ##1
                                 (stat[i2cba_pkg::EV_RX] || $past(rd_strobe || wr_strobe)))
      else $error("receive flag not set on byte");
endmodule // i2cba_top
`default_nettype wire
